// ===== core/scs_defs.svh
// Constants for the serializer clock source and self-test control block
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

`define SCS_CLK_PERIOD_NS     32'd100
`define SCS_LOCK_TIME_NS      32'd2000
`define SCS_LOCK_CYCLES       ((`SCS_LOCK_TIME_NS + `SCS_CLK_PERIOD_NS - 32'd1) / `SCS_CLK_PERIOD_NS)
`define SCS_LOST_TIME_NS      32'd1000
`define SCS_LOST_CYCLES       (`SCS_LOST_TIME_NS / `SCS_CLK_PERIOD_NS)
`define SCS_DETECT_EDGES      4'd4

`define SCS_ADDR_AUTOSWITCH   8'h03
`define SCS_ADDR_OSC_SELECT   8'h14
`define SCS_AUTOSWITCH_RESET  8'h01
`define SCS_OSC_SELECT_RESET  8'h00
`define SCS_EDGE_SEL_BIT      0
`define SCS_AUTOSW_OFF_BIT    1
`define SCS_OSC_LO_BIT        1
`define SCS_OSC_HI_BIT        2

`define SCS_OSC_FAST_CODE     2'b01
`define SCS_OSC_RSVD_CODE     2'b11
`define SCS_INT_DIV_FAST      4'd2
`define SCS_INT_DIV_SLOW      4'd4

`define SCS_STRAP_PIX_MIN     10'd750
`define SCS_STRAP_PIX_MAX     10'd1000
`define SCS_STRAP_EXT_MIN     10'd292
`define SCS_STRAP_EXT_MAX     10'd339

`define SCS_LFSR_SEED         12'hace

`endif

// ===== core/scs_pkg.sv
// Types for the serializer clock source and self-test control block
package scs_pkg;
  typedef enum logic [2:0] {
    ST_DOWN,
    ST_LOCK_INT,
    ST_RUN_INT,
    ST_LOCK_PIX,
    ST_RUN_PIX
  } scs_state_type;
endpackage

// ===== core/scs_clock_detect.sv
// Pixel clock activity detector working on filtered edge pulses
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"

module scs_clock_detect
  import scs_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic edge_seen,
  output var  logic active
);

  logic [7:0] idle_cnt_reg;
  logic [7:0] idle_cnt_next;
  logic [3:0] edge_cnt_reg;
  logic [3:0] edge_cnt_next;
  logic       active_reg;
  logic       active_next;

  // Several edges in a row make the clock valid; a long quiet spell drops it
  always_comb begin
    idle_cnt_next = idle_cnt_reg;
    edge_cnt_next = edge_cnt_reg;
    active_next   = active_reg;
    if (edge_seen) begin
      idle_cnt_next = 8'h00;
      if (edge_cnt_reg != `SCS_DETECT_EDGES) begin
        edge_cnt_next = edge_cnt_reg + 4'h1;
      end
      if (edge_cnt_next == `SCS_DETECT_EDGES) begin
        active_next = 1'b1;
      end
    end else if (idle_cnt_reg == 8'(`SCS_LOST_CYCLES)) begin
      edge_cnt_next = 4'h0;
      active_next   = 1'b0;
    end else begin
      idle_cnt_next = idle_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idle_cnt_reg <= 8'h00;
      edge_cnt_reg <= 4'h0;
      active_reg   <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_cnt_next;
      edge_cnt_reg <= edge_cnt_next;
      active_reg   <= active_next;
    end
  end

  assign active = active_reg;

endmodule // scs_clock_detect
`default_nettype wire

// ===== core/scs_clock_source.sv
// Serializer clock source selection, power-down, edge select and self-test framing
//
// Behaviour
// - Latch pixels on edge chosen by select bit
// - Power-down low: serial outputs static high
// - No pixel clock: run link from oscillator
// - Pixel clock returns: lock, resume pixel data
// - External oscillator halved onto general pin two
// - Four edges seen, switch-off bit clear: use pixel clock
// - Pixel clock lost: back to internal oscillator
// - Oscillator mode: pins two, three carry clocks
// - Pixel clock mode: all four pins general
// - Strap ratio selects pixel or oscillator mode
// - Oscillator field picks internal frame rate
// - Self test loads oscillator field remotely
// - Frame rate: pixel clock over 2 or 1.5
// - Self test sends pattern instead of pixels
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"

module scs_clock_source
  import scs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        power_down_n,
  input  wire logic        pixel_clock,
  input  wire logic [11:0] pixel_data,
  input  wire logic        ext_osc_in,
  input  wire logic        twelve_bit_mode,
  input  wire logic [9:0]  mode_strap_ratio,
  input  wire logic [3:0]  gp_remote_in,
  input  wire logic        bc_self_test,
  input  wire logic [1:0]  bc_osc_select,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             link_enable,
  output logic             serial_idle_high,
  output logic             on_internal_osc,
  output logic             frame_valid,
  output logic      [11:0] frame_data,
  output logic             frame_is_pattern,
  output logic             ext_osc_mode,
  output logic      [3:0]  gp_out,
  output logic      [3:0]  gp_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change accepted once stages two and three agree

  logic [2:0]  s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [11:0] d1_reg, d2_reg, d3_reg;
  logic        pix_rise_reg, pix_fall_reg, osc_rise_reg;
  logic        pix_rise_next, pix_fall_next, osc_rise_next;

  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i < 3; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
    pix_rise_next = filt_next[1] & ~filt_reg[1];
    pix_fall_next = ~filt_next[1] & filt_reg[1];
    osc_rise_next = filt_next[2] & ~filt_reg[2];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_reg <= 3'h0; s2_reg <= 3'h0; s3_reg <= 3'h0; filt_reg <= 3'h0;
      d1_reg <= 12'h000; d2_reg <= 12'h000; d3_reg <= 12'h000;
      pix_rise_reg <= 1'b0; pix_fall_reg <= 1'b0; osc_rise_reg <= 1'b0;
    end else begin
      s1_reg <= {ext_osc_in, pixel_clock, power_down_n};
      s2_reg <= s1_reg; s3_reg <= s2_reg; filt_reg <= filt_next;
      d1_reg <= pixel_data; d2_reg <= d1_reg; d3_reg <= d2_reg;
      pix_rise_reg <= pix_rise_next; pix_fall_reg <= pix_fall_next;
      osc_rise_reg <= osc_rise_next;
    end
  end

  logic pd_n_filt;
  logic pix_active;
  assign pd_n_filt = filt_reg[0];

  scs_clock_detect u_detect (
    .clock     (clock),
    .rst_n     (rst_n),
    .edge_seen (pix_rise_reg),
    .active    (pix_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Registers, strap and self-test command

  logic [7:0] autosw_reg, autosw_next, osc_reg, osc_next, rdata_reg, rdata_next;
  logic       strap_done_reg, strap_done_next, ext_mode_reg, ext_mode_next;
  logic       test_reg, test_next;

  function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo,
                                    input logic [9:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  always_comb begin
    autosw_next     = autosw_reg;
    osc_next        = osc_reg;
    strap_done_next = 1'b1;
    ext_mode_next   = ext_mode_reg;
    test_next       = bc_self_test;
    if (!strap_done_reg) begin
      if (in_range(mode_strap_ratio, `SCS_STRAP_EXT_MIN, `SCS_STRAP_EXT_MAX)) begin
        ext_mode_next = 1'b1;
      end else if (in_range(mode_strap_ratio, `SCS_STRAP_PIX_MIN, `SCS_STRAP_PIX_MAX)) begin
        ext_mode_next = 1'b0;
      end
    end
    if (reg_write && reg_addr == `SCS_ADDR_AUTOSWITCH) begin
      autosw_next = reg_wdata;
    end
    if (reg_write && reg_addr == `SCS_ADDR_OSC_SELECT) begin
      osc_next = reg_wdata;
    end
    if (test_reg) begin
      osc_next[`SCS_OSC_HI_BIT:`SCS_OSC_LO_BIT] = bc_osc_select;
    end
    unique case (reg_addr)
      `SCS_ADDR_AUTOSWITCH: rdata_next = autosw_reg;
      `SCS_ADDR_OSC_SELECT: rdata_next = osc_reg;
      default:              rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      autosw_reg <= `SCS_AUTOSWITCH_RESET; osc_reg <= `SCS_OSC_SELECT_RESET;
      rdata_reg <= 8'h00; strap_done_reg <= 1'b0; ext_mode_reg <= 1'b0; test_reg <= 1'b0;
    end else begin
      autosw_reg <= autosw_next; osc_reg <= osc_next; rdata_reg <= rdata_next;
      strap_done_reg <= strap_done_next; ext_mode_reg <= ext_mode_next;
      test_reg <= test_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock source state machine and frame generation

  scs_state_type state_reg, state_next;
  logic [7:0]  lock_cnt_reg, lock_cnt_next;
  logic [3:0]  tick_cnt_reg, tick_cnt_next;
  logic [1:0]  phase_reg, phase_next;
  logic [11:0] pix_hold_reg, pix_hold_next, lfsr_reg, lfsr_next;
  logic [11:0] fdata_next;
  logic        fvalid_next, fpat_next, half_ref_reg, half_ref_next;
  logic [3:0]  gp_out_next, gp_oe_n_next;
  logic        want_pixel, take, int_tick;
  logic [3:0]  int_div;
  logic [1:0]  osc_field;

  assign osc_field  = osc_reg[`SCS_OSC_HI_BIT:`SCS_OSC_LO_BIT];
  // Test clock select 00 means pixel clock; any other code keeps the internal one
  assign want_pixel = pix_active && !autosw_reg[`SCS_AUTOSW_OFF_BIT] &&
                      !(test_reg && bc_osc_select != 2'b00);
  assign take       = autosw_reg[`SCS_EDGE_SEL_BIT] ? pix_rise_reg : pix_fall_reg;
  // Reserved code falls back to the slow rate
  assign int_div    = (osc_field == `SCS_OSC_FAST_CODE) ? `SCS_INT_DIV_FAST
                                                        : `SCS_INT_DIV_SLOW;
  assign int_tick   = (tick_cnt_reg == int_div - 4'h1);

  always_comb begin
    state_next    = state_reg;
    lock_cnt_next = lock_cnt_reg;
    tick_cnt_next = 4'h0;
    phase_next    = phase_reg;
    pix_hold_next = pix_hold_reg;
    lfsr_next     = lfsr_reg;
    fvalid_next   = 1'b0;
    fdata_next    = frame_data;
    fpat_next     = frame_is_pattern;
    half_ref_next = half_ref_reg;
    if (ext_mode_reg && osc_rise_reg) begin
      half_ref_next = ~half_ref_reg;
    end
    unique case (state_reg)
      ST_DOWN: begin
        if (pd_n_filt) begin
          state_next    = ST_LOCK_INT;
          lock_cnt_next = 8'(`SCS_LOCK_CYCLES);
        end
      end
      ST_LOCK_INT, ST_LOCK_PIX: begin
        phase_next = 2'b00;
        if (state_reg == ST_LOCK_PIX && !want_pixel) begin
          state_next    = ST_LOCK_INT;
          lock_cnt_next = 8'(`SCS_LOCK_CYCLES);
        end else if (lock_cnt_reg == 8'h00) begin
          state_next = (state_reg == ST_LOCK_PIX) ? ST_RUN_PIX : ST_RUN_INT;
        end else begin
          lock_cnt_next = lock_cnt_reg - 8'h01;
        end
      end
      ST_RUN_INT: begin
        tick_cnt_next = int_tick ? 4'h0 : tick_cnt_reg + 4'h1;
        fvalid_next   = int_tick;
        if (want_pixel) begin
          state_next    = ST_LOCK_PIX;
          lock_cnt_next = 8'(`SCS_LOCK_CYCLES);
          fvalid_next   = 1'b0;
        end
      end
      ST_RUN_PIX: begin
        if (!want_pixel) begin
          state_next    = ST_LOCK_INT;
          lock_cnt_next = 8'(`SCS_LOCK_CYCLES);
        end else if (take) begin
          pix_hold_next = d3_reg;
          // One frame per two pixels, or two frames per three pixels
          if (twelve_bit_mode) begin
            phase_next  = (phase_reg == 2'b10) ? 2'b00 : phase_reg + 2'b01;
            fvalid_next = (phase_reg != 2'b00);
          end else begin
            phase_next  = {1'b0, ~phase_reg[0]};
            fvalid_next = phase_reg[0];
          end
        end
      end
    endcase
    if (!pd_n_filt) begin
      state_next  = ST_DOWN;
      fvalid_next = 1'b0;
    end
    if (fvalid_next) begin
      fpat_next = test_reg;
      if (test_reg) begin
        lfsr_next  = {lfsr_reg[10:0], lfsr_reg[11] ^ lfsr_reg[5] ^ lfsr_reg[3] ^ lfsr_reg[0]};
        fdata_next = lfsr_reg;
      end else begin
        fdata_next = (state_reg == ST_RUN_PIX) ? pix_hold_next : 12'h000;
      end
    end
    // Clock pins leave the general pool in oscillator mode
    gp_out_next  = gp_remote_in;
    gp_oe_n_next = 4'h0;
    if (ext_mode_reg) begin
      gp_out_next[2]  = half_ref_next;
      gp_out_next[3]  = 1'b0;
      gp_oe_n_next[3] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_DOWN; lock_cnt_reg <= 8'h00; tick_cnt_reg <= 4'h0;
      phase_reg <= 2'b00; pix_hold_reg <= 12'h000; lfsr_reg <= `SCS_LFSR_SEED;
      half_ref_reg <= 1'b0; frame_valid <= 1'b0; frame_data <= 12'h000;
      frame_is_pattern <= 1'b0; link_enable <= 1'b0; serial_idle_high <= 1'b1;
      on_internal_osc <= 1'b1; gp_out <= 4'h0; gp_oe_n <= 4'hf;
    end else begin
      state_reg <= state_next; lock_cnt_reg <= lock_cnt_next;
      tick_cnt_reg <= tick_cnt_next; phase_reg <= phase_next;
      pix_hold_reg <= pix_hold_next; lfsr_reg <= lfsr_next; half_ref_reg <= half_ref_next;
      frame_valid <= fvalid_next; frame_data <= fdata_next; frame_is_pattern <= fpat_next;
      link_enable <= (state_next != ST_DOWN);
      serial_idle_high <= (state_next != ST_RUN_INT) && (state_next != ST_RUN_PIX);
      on_internal_osc <= (state_next != ST_RUN_PIX) && (state_next != ST_LOCK_PIX);
      gp_out <= gp_out_next; gp_oe_n <= gp_oe_n_next;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign ext_osc_mode = ext_mode_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seq_pix_lost;
    state_reg == ST_RUN_PIX && !want_pixel && pd_n_filt;
  endsequence
  sequence seq_back_to_int;
    state_reg == ST_LOCK_INT ##1 !frame_valid;
  endsequence

  a_down_static_high: assert property (state_reg == ST_DOWN && !pd_n_filt
    |=> serial_idle_high && !link_enable) else $error("link not idle in power down");
  a_lock_no_frames: assert property (state_reg == ST_LOCK_PIX |=> !frame_valid)
    else $error("frame sent before lock");
  a_pix_switch: assert property (state_reg == ST_RUN_INT && want_pixel && pd_n_filt
    |=> state_reg == ST_LOCK_PIX && on_internal_osc == 1'b0)
    else $error("no switch to pixel clock");
  a_pix_lost_back: assert property (seq_pix_lost |=> seq_back_to_int)
    else $error("no return to internal oscillator");
  a_half_ref_toggle: assert property (ext_mode_reg && osc_rise_reg
    |=> gp_out[2] != $past(gp_out[2])) else $error("reference not halved");
  a_gp_all_free: assert property (!ext_mode_reg |=> gp_oe_n == 4'h0)
    else $error("general pins not all driven");
  a_gp_clock_pins: assert property (ext_mode_reg
    |=> gp_oe_n[3] && gp_out[2] == half_ref_reg)
    else $error("clock pins used as general outputs");
  a_test_pattern: assert property (fvalid_next && test_reg
    |=> frame_valid && frame_is_pattern) else $error("pixels sent in self test");
  a_osc_remote_load: assert property (test_reg
    |=> osc_reg[2:1] == $past(bc_osc_select)) else $error("field not loaded remotely");
  a_int_lock_exit: assert property (state_reg == ST_LOCK_INT && lock_cnt_reg == 8'h00
    && pd_n_filt |=> state_reg == ST_RUN_INT) else $error("internal run not reached");

endmodule // scs_clock_source
`default_nettype wire

// ===== tb/scs_imager_model.sv
// Imager model: pixel clock, pixel words and external oscillator
`timescale 1ns/100ps
`default_nettype none

module scs_imager_model #(
  parameter int HALF = 4
) (
  input  wire logic        clock,
  input  wire logic        pix_run,
  input  wire logic        osc_run,
  input  wire logic        twelve_bit_mode,
  output logic             pixel_clock,
  output logic      [11:0] pixel_data,
  output logic             ext_osc_in
);
  int ph;
  int oc;

  ////////////////////////////////////////////////////////////////////////////
  // Clock stands low between runs; words change mid-phase so that rising
  // edges see even words and falling edges odd ones
  always @(posedge clock) begin
    if (!pix_run) begin
      ph <= 0;
      pixel_clock <= 1'b0;
      pixel_data <= 12'h000;
    end else begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == 0) begin
        pixel_clock <= ~pixel_clock;
      end
      if (ph == HALF / 2) begin
        pixel_data <= pixel_data + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator runs alongside the pixel clock at half its rate, or two thirds of it in twelve-bit mode
  always @(posedge clock) begin
    if (!osc_run) begin
      oc <= 0;
      ext_osc_in <= 1'b0;
    end else begin
      oc <= (oc >= (twelve_bit_mode ? HALF * 3 / 2 : HALF * 2) - 1) ? 0 : oc + 1;
      if (oc == 0) begin
        ext_osc_in <= ~ext_osc_in;
      end
    end
  end
endmodule // scs_imager_model

`default_nettype wire

// ===== tb/tb_serializer_clock_source_bist.sv
// Self-checking bench for the serializer clock source block
`timescale 1ns/100ps
`default_nettype none

module tb_serializer_clock_source_bist
  import scs_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        power_down_n = 1'b0;
  logic        twelve_bit_mode = 1'b0;
  logic [9:0]  mode_strap_ratio = 10'h3e8;
  logic [3:0]  gp_remote_in = 4'ha;
  logic        bc_self_test = 1'b0;
  logic [1:0]  bc_osc_select = 2'h0;
  logic        reg_write = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        pix_run = 1'b0;
  logic        osc_run = 1'b0;
  logic        pixel_clock;
  logic        ext_osc_in;
  logic [11:0] pixel_data;
  logic [7:0]  reg_rdata;
  logic        link_enable;
  logic        serial_idle_high;
  logic        on_internal_osc;
  logic        frame_valid;
  logic [11:0] frame_data;
  logic        frame_is_pattern;
  logic        ext_osc_mode;
  logic [3:0]  gp_out;
  logic [3:0]  gp_oe_n;
  int          err_total = 0;
  int          checks_done = 0;

  always #50 clock = ~clock;

  scs_imager_model #(.HALF(4)) imager (
    .clock(clock), .pix_run(pix_run), .osc_run(osc_run),
    .twelve_bit_mode(twelve_bit_mode), .pixel_clock(pixel_clock),
    .pixel_data(pixel_data), .ext_osc_in(ext_osc_in)
  );

  scs_clock_source dut (
    .clock(clock), .rst_n(rst_n), .power_down_n(power_down_n),
    .pixel_clock(pixel_clock), .pixel_data(pixel_data), .ext_osc_in(ext_osc_in),
    .twelve_bit_mode(twelve_bit_mode), .mode_strap_ratio(mode_strap_ratio),
    .gp_remote_in(gp_remote_in), .bc_self_test(bc_self_test),
    .bc_osc_select(bc_osc_select), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_enable(link_enable),
    .serial_idle_high(serial_idle_high), .on_internal_osc(on_internal_osc),
    .frame_valid(frame_valid), .frame_data(frame_data),
    .frame_is_pattern(frame_is_pattern), .ext_osc_mode(ext_osc_mode),
    .gp_out(gp_out), .gp_oe_n(gp_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    tick(2);
    chk("reg_rdata", {4'h0, exp}, {4'h0, reg_rdata});
  endtask

  // Bounded wait for frame_valid (frm) or on_internal_osc to reach want
  task automatic wait_on(input bit frm, input logic want);
    int n;
    n = 0;
    tick(1);
    while ((frm ? frame_valid : on_internal_osc) !== want) begin
      tick(1);
      n++;
      if (n > 400) begin
        $display("BAD wait expected %h seen timeout", want);
        err_total++;
        return;
      end
    end
  endtask

  task automatic gap(input int exp);
    int g;
    tick(8);
    wait_on(1'b1, 1'b1);
    g = 0;
    do begin
      tick(1);
      g++;
    end while (frame_valid !== 1'b1 && g < 300);
    chk("frame gap", 12'(exp), 12'(g));
  endtask

  task automatic frames_in(input int win, input int exp);
    int n;
    n = 0;
    wait_on(1'b1, 1'b1);
    repeat (win) begin
      tick(1);
      if (frame_valid === 1'b1) n++;
    end
    chk("frames", 12'(exp), 12'(n));
  endtask

  task automatic idle_for(input int n);
    repeat (n) begin
      tick(1);
      chk("idle", 12'h002, {10'h0, serial_idle_high, frame_valid});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'h03, 8'h01);
    rd(8'h14, 8'h00);
    wr(8'h14, 8'h02);
    rd(8'h14, 8'h02);
    wr(8'h14, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    chk("link down", 12'h000, {11'h0, link_enable});
    idle_for(20);
  endtask

  task automatic t_internal();
    @(posedge clock);
    power_down_n <= 1'b1;
    idle_for(20);
    gap(4);
    chk("link on", 12'h003, {10'h0, link_enable, on_internal_osc});
    wr(8'h14, 8'h02);
    gap(2);
    wr(8'h14, 8'h04);
    gap(4);
    wr(8'h14, 8'h00);
  endtask

  task automatic t_pixel(input logic edge_sel);
    logic [11:0] d0;
    wr(8'h03, {7'h0, edge_sel});
    @(posedge clock);
    pix_run <= 1'b1;
    wait_on(1'b0, 1'b0);
    idle_for(15);
    wait_on(1'b1, 1'b1);
    d0 = frame_data;
    chk("latch edge", {11'h0, ~edge_sel}, {11'h0, frame_data[0]});
    wait_on(1'b1, 1'b1);
    chk("pixel step", d0 + 12'h004, frame_data);
    chk("pattern", 12'h000, {11'h0, frame_is_pattern});
    frames_in(48, 3);
    @(posedge clock);
    twelve_bit_mode <= 1'b1;
    frames_in(48, 4);
    @(posedge clock);
    twelve_bit_mode <= 1'b0;
    pix_run <= 1'b0;
    wait_on(1'b0, 1'b1);
    gap(4);
  endtask

  task automatic t_autosw();
    wr(8'h03, 8'h03);
    @(posedge clock);
    pix_run <= 1'b1;
    repeat (80) begin
      tick(1);
      chk("autoswitch off", 12'h001, {11'h0, on_internal_osc});
    end
    @(posedge clock);
    pix_run <= 1'b0;
    wr(8'h03, 8'h01);
    tick(20);
  endtask

  task automatic t_self_test();
    for (int i = 1; i < 3; i++) begin
      @(posedge clock);
      bc_self_test <= 1'b1;
      bc_osc_select <= 2'(i);
      tick(40);
      wr(8'h14, 8'h00);
      rd(8'h14, {5'h0, 2'(i), 1'b0});
      gap(i == 1 ? 2 : 4);
      chk("pattern", 12'h001, {11'h0, frame_is_pattern});
    end
    // Bench stands in for the deserializer and ends the run by dropping the enable
    @(posedge clock);
    bc_self_test <= 1'b0;
    bc_osc_select <= 2'h0;
    tick(40);
    wait_on(1'b1, 1'b1);
    chk("pattern off", 12'h000, {11'h0, frame_is_pattern});
  endtask

  task automatic t_strap();
    int r [6] = '{750, 1000, 291, 340, 292, 339};
    int n;
    logic p;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      mode_strap_ratio <= 10'(r[i]);
      rst_n <= 1'b0;
      tick(2);
      @(posedge clock);
      rst_n <= 1'b1;
      tick(4);
      chk("strap mode", 12'(i / 4), {11'h0, ext_osc_mode});
      if (i < 4) begin
        chk("gp pins", 12'h00a, {4'h0, gp_oe_n, gp_out});
      end else begin
        chk("clock pins", 12'h002, {10'h0, gp_oe_n[3:2]});
      end
    end
    @(posedge clock);
    osc_run <= 1'b1;
    gp_remote_in <= 4'hf;
    tick(40);
    n = 0;
    p = gp_out[2];
    repeat (96) begin
      tick(1);
      if (gp_out[2] !== p) n++;
      p = gp_out[2];
    end
    chk("half clock toggles", 12'h006, 12'(n));
  endtask

  initial begin
    tick(5);
    @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_internal();
    t_pixel(1'b1);
    t_pixel(1'b0);
    t_autosw();
    t_self_test();
    t_strap();
    conclude();
  end
endmodule // tb_serializer_clock_source_bist

`default_nettype wire
